// *** rtl/aort_consts.svh ***
`ifndef AORT_CONSTS_SVH
`define AORT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AORT_ADR_CTRL 8'h00
`define AORT_ADR_LOW 8'h04
`define AORT_ADR_HIGH 8'h08
`define AORT_ADR_SETPT 8'h0C
`define AORT_ADR_SPAN 8'h10
`define AORT_ADR_PGAIN 8'h14
`define AORT_ADR_IGAIN 8'h18
`define AORT_ADR_IHI 8'h1C
`define AORT_ADR_ILO 8'h20
`define AORT_ADR_ACCEPT 8'h24
`define AORT_ADR_STATUS 8'h28
`define AORT_ADR_CODE 8'h2C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AORT_CTRL_PI 0
`define AORT_CTRL_SRC 1
`define AORT_ACCEPT_GO 0
`define AORT_STAT_FIT 0
`define AORT_STAT_PI 1
`define AORT_STAT_TOT 2
`define AORT_STAT_BUSY 3

// ----------------------------------------------------------------------
// Reset values, in display units, thousandths or tenths of a percent
// ----------------------------------------------------------------------
`define AORT_DEF_LOW 32'h0000_0000
`define AORT_DEF_HIGH 32'h0000_03E8
`define AORT_DEF_SETPT 32'h0000_0000
`define AORT_DEF_SPAN 32'h0000_03E8
`define AORT_DEF_PGAIN 16'h03E8
`define AORT_DEF_IGAIN 16'h0000
`define AORT_DEF_IHI 16'h03E8
`define AORT_DEF_ILO 16'h0000

// ----------------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------------
`define AORT_PERMILLE 48'h0000_0000_03E8
`define AORT_CODE_MAX 48'h0000_0000_FFFF
`define AORT_ERR_LIM 48'h0000_0001_86A0
`define AORT_CLK_HZ 32'h02FA_F080
`define AORT_UPDATE_MS 32'h0000_0064
`define AORT_MS_PER_S 32'h0000_03E8

`endif

// *** rtl/aort_pkg.sv ***
`include "aort_consts.svh"
`default_nettype none

package aort_pkg;

  // --------------------------------------------------------------------
  // Operating mode of the instrument and control sequence
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    AORT_MODE_RATE = 2'h0,
    AORT_MODE_TOTAL = 2'h1,
    AORT_MODE_BOTH = 2'h2
  } aort_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_ERR, SEQ_PROP, SEQ_INT, SEQ_FIN
  } aort_seq_t;

  // --------------------------------------------------------------------
  // One set of output parameters
  // --------------------------------------------------------------------
  typedef struct packed {
    logic pi_en;
    logic src_tot;
    logic signed [31:0] low;
    logic signed [31:0] high;
    logic signed [31:0] setpt;
    logic signed [31:0] span;
    logic signed [15:0] pgain;
    logic signed [15:0] igain;
    logic [15:0] ihi;
    logic [15:0] ilo;
  } aort_cfg_t;

  localparam aort_cfg_t AORT_CFG_DEFAULT = '{
    pi_en: 1'b0, src_tot: 1'b0,
    low: `AORT_DEF_LOW, high: `AORT_DEF_HIGH,
    setpt: `AORT_DEF_SETPT, span: `AORT_DEF_SPAN,
    pgain: `AORT_DEF_PGAIN, igain: `AORT_DEF_IGAIN,
    ihi: `AORT_DEF_IHI, ilo: `AORT_DEF_ILO
  };

endpackage

`default_nettype wire

// *** rtl/aort_div.sv ***
`default_nettype none

// Serial signed-by-unsigned divider, one quotient bit per clock.
module aort_div #(
  parameter int W = 48
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic signed [W-1:0] num_i,
  input wire logic [W-1:0] den_i,
  output logic done_o,
  output logic signed [W-1:0] quo_o
);
  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic busy;
    logic neg;
    logic done;
    logic [CW-1:0] cnt;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] den;
  } aort_div_state_t;

  aort_div_state_t q, d;

  always_comb begin
    logic [W:0] trial;
    logic [W-1:0] nq;
    trial = {q.rem, q.quo[W-1]} - {1'b0, q.den};
    nq = '0;
    d = q;
    d.done = 1'b0;
    if (start_i) begin
      d.neg = num_i[W-1];
      d.quo = num_i[W-1] ? -num_i : num_i;
      d.rem = '0;
      d.den = den_i;
      d.cnt = CW'(W);
      d.busy = (den_i != '0);
      // A zero divisor answers zero at once.
      if (den_i == '0) begin
        d.quo = '0;
        d.done = 1'b1;
      end
    end else if (q.busy) begin
      if (!trial[W]) begin
        d.rem = trial[W-1:0];
        nq = {q.quo[W-2:0], 1'b1};
      end else begin
        d.rem = {q.rem[W-2:0], q.quo[W-1]};
        nq = {q.quo[W-2:0], 1'b0};
      end
      d.quo = nq;
      d.cnt = q.cnt - CW'(1);
      if (q.cnt == CW'(1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.quo = q.neg ? -nq : nq;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;
  assign quo_o = q.quo;

endmodule // aort_div

`default_nettype wire

// *** rtl/aort_top.sv ***
// What this block does
// - Parameters reachable only with output option fitted
// - Output follows a selectable source value
// - Source is rate value or total value
// - Source choice only in combined mode
// - PI off: linear retransmission between points
// - PI on: control output, tuning exposed, default off
// - Low point, default zero, gives minimum output
// - High point, default 1000, gives full scale
// - Setpoint held, default zero
// - Span held, default 1000
// - Signed proportional gain, default 1.000
// - Integral gain, default 0.000
// - Integral upper clamp, 0 to 100.0 percent
// - Integral lower clamp, 0 to 100.0 percent
`include "aort_consts.svh"
`default_nettype none

module aort_top #(
  parameter int UPDATE_CYCLES =
    int'(`AORT_UPDATE_MS * (`AORT_CLK_HZ / `AORT_MS_PER_S)),
  parameter int DIV_W = 48
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic option_fitted_i,
  input wire aort_pkg::aort_mode_t op_mode_i,
  input wire logic signed [31:0] rate_value_i,
  input wire logic signed [31:0] total_value_i,
  output logic [15:0] dac_code_o,
  output logic param_visible_o,
  output logic pi_active_o,
  output logic src_total_o
);
  import aort_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic fit_m;
    logic fit_s;
    logic ack;
    logic [31:0] dat;
    aort_cfg_t stg;
    aort_cfg_t act;
    aort_seq_t seq;
    logic [31:0] tmr;
    logic tick;
    logic src_tot;
    logic signed [31:0] src;
    logic signed [31:0] err;
    logic signed [31:0] prop;
    logic signed [15:0] integ;
    logic go;
    logic signed [DIV_W-1:0] num;
    logic [DIV_W-1:0] den;
    logic [15:0] code;
  } aort_state_t;

  aort_state_t q, d;
  logic div_done;
  logic signed [DIV_W-1:0] div_quo;
  logic req;
  logic wr;
  logic accept_w;
  logic src_tot_eff;

  function automatic logic [31:0] aort_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [DIV_W-1:0] aort_clamp(
      input logic signed [DIV_W-1:0] v,
      input logic signed [DIV_W-1:0] floor_v,
      input logic signed [DIV_W-1:0] ceil_v);
    logic signed [DIV_W-1:0] r;
    r = v;
    if (r < floor_v) begin
      r = floor_v;
    end
    if (r > ceil_v) begin
      r = ceil_v;
    end
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Shared divider
  // --------------------------------------------------------------------
  aort_div #(
    .W(DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(q.go),
    .num_i(q.num),
    .den_i(q.den),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic signed [DIV_W-1:0] a;
    logic signed [DIV_W-1:0] b;
    logic signed [DIV_W-1:0] t;
    logic signed [DIV_W-1:0] lim;
    rd = '0;
    wv = '0;
    a = '0;
    b = '0;
    t = '0;
    lim = `AORT_ERR_LIM;
    d = q;

    // The option strap is a pin, so it is synchronised first.
    d.fit_m = option_fitted_i;
    d.fit_s = q.fit_m;

    // Bus: one wait state, the write lands on the acknowledging edge.
    req = wb_cyc_i && wb_stb_i;
    d.ack = req && !q.ack;
    wr = req && q.ack && wb_we_i && q.fit_s;
    accept_w = 1'b0;
    unique case (wb_adr_i)
      `AORT_ADR_CTRL: begin
        rd[`AORT_CTRL_PI] = q.stg.pi_en;
        rd[`AORT_CTRL_SRC] = q.stg.src_tot;
      end
      `AORT_ADR_LOW: rd = q.stg.low;
      `AORT_ADR_HIGH: rd = q.stg.high;
      `AORT_ADR_SETPT: rd = q.act.pi_en ? q.stg.setpt : '0;
      `AORT_ADR_SPAN: rd = q.act.pi_en ? q.stg.span : '0;
      `AORT_ADR_PGAIN: rd = q.act.pi_en ? 32'(q.stg.pgain) : '0;
      `AORT_ADR_IGAIN: rd = q.act.pi_en ? 32'(q.stg.igain) : '0;
      `AORT_ADR_IHI: rd = q.act.pi_en ? 32'(q.stg.ihi) : '0;
      `AORT_ADR_ILO: rd = q.act.pi_en ? 32'(q.stg.ilo) : '0;
      `AORT_ADR_STATUS: begin
        rd[`AORT_STAT_FIT] = q.fit_s;
        rd[`AORT_STAT_PI] = q.act.pi_en;
        rd[`AORT_STAT_TOT] = q.src_tot;
        rd[`AORT_STAT_BUSY] = (q.seq != SEQ_IDLE);
      end
      `AORT_ADR_CODE: rd = 32'(q.code);
      default: rd = '0;
    endcase
    // Hidden parameters read as zero; status stays readable.
    if (!q.fit_s && wb_adr_i != `AORT_ADR_STATUS) begin
      rd = '0;
    end
    d.dat = (req && !q.ack && !wb_we_i) ? rd : '0;

    if (wr) begin
      wv = aort_merge(rd, wb_dat_i, wb_sel_i);
      unique case (wb_adr_i)
        `AORT_ADR_CTRL: begin
          d.stg.pi_en = wv[`AORT_CTRL_PI];
          d.stg.src_tot = wv[`AORT_CTRL_SRC];
        end
        `AORT_ADR_LOW: d.stg.low = wv;
        `AORT_ADR_HIGH: d.stg.high = wv;
        `AORT_ADR_SETPT: if (q.act.pi_en) d.stg.setpt = wv;
        `AORT_ADR_SPAN: if (q.act.pi_en) d.stg.span = wv;
        `AORT_ADR_PGAIN: if (q.act.pi_en) d.stg.pgain = wv[15:0];
        `AORT_ADR_IGAIN: if (q.act.pi_en) d.stg.igain = wv[15:0];
        `AORT_ADR_IHI: begin
          if (q.act.pi_en && wv[15:0] <= `AORT_DEF_IHI) begin
            d.stg.ihi = wv[15:0];
          end
        end
        `AORT_ADR_ILO: begin
          if (q.act.pi_en && wv[15:0] <= `AORT_DEF_IHI) begin
            d.stg.ilo = wv[15:0];
          end
        end
        `AORT_ADR_ACCEPT: accept_w = wb_dat_i[`AORT_ACCEPT_GO];
        default: ;
      endcase
    end
    // Edited values reach the output only on an accept.
    if (accept_w) begin
      d.act = q.stg;
    end

    // Source follows the mode unless the mode shows both values.
    if (op_mode_i == AORT_MODE_BOTH) begin
      src_tot_eff = q.act.src_tot;
    end else begin
      src_tot_eff = (op_mode_i == AORT_MODE_TOTAL);
    end

    // Control update tick.
    d.tick = 1'b0;
    if (q.tmr >= 32'(UPDATE_CYCLES - 1)) begin
      d.tmr = '0;
      d.tick = 1'b1;
    end else begin
      d.tmr = q.tmr + 32'h1;
    end

    d.go = 1'b0;
    unique case (q.seq)
      SEQ_IDLE: begin
        if (q.tick) begin
          d.src_tot = src_tot_eff;
          d.src = src_tot_eff ? total_value_i : rate_value_i;
          if (q.act.pi_en) begin
            a = (DIV_W'(q.act.setpt) - DIV_W'(d.src)) * `AORT_PERMILLE;
            b = DIV_W'(q.act.span);
            d.seq = SEQ_ERR;
          end else begin
            a = (DIV_W'(d.src) - DIV_W'(q.act.low)) * `AORT_CODE_MAX;
            b = DIV_W'(q.act.high) - DIV_W'(q.act.low);
            d.seq = SEQ_FIN;
          end
          // A reversed range flips the sign of both terms.
          d.num = (b < 0) ? -a : a;
          d.den = (b < 0) ? -b : b;
          d.go = 1'b1;
        end
      end
      SEQ_ERR: begin
        if (div_done) begin
          t = aort_clamp(div_quo, -lim, lim);
          d.err = 32'(t);
          d.num = DIV_W'(q.act.pgain) * t;
          d.den = `AORT_PERMILLE;
          d.go = 1'b1;
          d.seq = SEQ_PROP;
        end
      end
      SEQ_PROP: begin
        if (div_done) begin
          d.prop = 32'(aort_clamp(div_quo, -lim, lim));
          d.num = DIV_W'(q.act.igain) * DIV_W'(q.err);
          d.den = `AORT_PERMILLE;
          d.go = 1'b1;
          d.seq = SEQ_INT;
        end
      end
      SEQ_INT: begin
        if (div_done) begin
          t = aort_clamp(DIV_W'(q.integ) + div_quo,
                         DIV_W'(q.act.ilo), DIV_W'(q.act.ihi));
          d.integ = 16'(t);
          t = aort_clamp(DIV_W'(q.prop) + t, '0, `AORT_PERMILLE);
          d.num = t * `AORT_CODE_MAX;
          d.den = `AORT_PERMILLE;
          d.go = 1'b1;
          d.seq = SEQ_FIN;
        end
      end
      SEQ_FIN: begin
        if (div_done) begin
          d.code = 16'(aort_clamp(div_quo, '0, `AORT_CODE_MAX));
          d.seq = SEQ_IDLE;
        end
      end
      default: d.seq = SEQ_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.stg <= AORT_CFG_DEFAULT;
      q.act <= AORT_CFG_DEFAULT;
      q.seq <= SEQ_IDLE;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign dac_code_o = q.code;
  assign param_visible_o = q.fit_s;
  assign pi_active_o = q.act.pi_en;
  assign src_total_o = q.src_tot;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_fit_visible: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 2) && !$past(rst_i, 1) |->
      param_visible_o == $past(option_fitted_i, 2))
    else $error("visibility does not follow option strap");

  a_src_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_IDLE && q.tick && op_mode_i != AORT_MODE_BOTH |=>
      src_total_o == ($past(op_mode_i) == AORT_MODE_TOTAL))
    else $error("source not fixed by operating mode");

  a_src_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_IDLE && q.tick && src_tot_eff |=>
      q.src == $past(total_value_i))
    else $error("total source not captured");

  a_mode_path: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_IDLE && q.tick |=>
      q.seq == ($past(q.act.pi_en) ? SEQ_ERR : SEQ_FIN))
    else $error("wrong path for control mode");

  a_retx_low: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_FIN && div_done && !q.act.pi_en &&
      q.act.high > q.act.low && q.src <= q.act.low |=>
      dac_code_o == 16'h0000)
    else $error("low point does not give minimum code");

  a_retx_high: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_FIN && div_done && !q.act.pi_en &&
      q.act.high > q.act.low && q.src >= q.act.high |=>
      dac_code_o == 16'hFFFF)
    else $error("high point does not give full scale");

  a_int_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == SEQ_INT && div_done && q.act.ilo <= q.act.ihi |=>
      $signed(q.integ) >= $signed({1'b0, q.act.ilo}) &&
      $signed(q.integ) <= $signed({1'b0, q.act.ihi}))
    else $error("integral term outside its clamps");

  a_accept_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !accept_w |=> $stable(q.act))
    else $error("active parameters changed without accept");

  a_reset_dflt: assert property (@(posedge clk_i)
    rst_i |=> !pi_active_o && q.act.span == `AORT_DEF_SPAN &&
      q.act.pgain == `AORT_DEF_PGAIN && q.act.igain == `AORT_DEF_IGAIN &&
      q.act.setpt == `AORT_DEF_SETPT)
    else $error("parameters not at defaults after reset");

  a_code_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(q.seq == SEQ_FIN && div_done) |=> $stable(dac_code_o))
    else $error("output code changed outside an update");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for two cycles");

endmodule // aort_top

`default_nettype wire

// *** bench/aort_dac_model.sv ***
`default_nettype none

// Output stage seen as a 0 to 10 V converter; reports the level it would
// produce and how often the code it receives has changed.
module aort_dac_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] code_i,
  output logic [31:0] level_uv_o,
  output logic [31:0] change_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] prev_q;
  logic [63:0] scaled;

  assign scaled = 64'(code_i) * 64'h0000_0000_0098_9680;
  assign level_uv_o = 32'(scaled / 64'h0000_0000_0000_FFFF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 16'h0000;
      change_cnt_o <= 32'h0000_0000;
    end else if (code_i !== prev_q) begin
      prev_q <= code_i;
      change_cnt_o <= change_cnt_o + 32'h0000_0001;
    end
  end
endmodule // aort_dac_model

`default_nettype wire

// *** bench/aort_top_tb.sv ***
`include "aort_consts.svh"
`default_nettype none

module aort_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aort_pkg::*;

  localparam int UPD = 400;

  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, fitted;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o, level_uv, chg_cnt, chg_before, st;
  logic wb_ack_o, param_visible_o, pi_active_o, src_total_o;
  logic [15:0] dac_code_o;
  aort_mode_t mode;
  logic signed [31:0] rate, total;
  int error_cnt = 0;
  int compares = 0;

  aort_top #(.UPDATE_CYCLES(UPD)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .option_fitted_i(fitted), .op_mode_i(mode), .rate_value_i(rate),
    .total_value_i(total), .dac_code_o(dac_code_o),
    .param_visible_o(param_visible_o), .pi_active_o(pi_active_o),
    .src_total_o(src_total_o)
  );

  aort_dac_model stage (
    .clk_i(clk_i), .rst_i(rst_i), .code_i(dac_code_o),
    .level_uv_o(level_uv), .change_cnt_o(chg_cnt)
  );

  initial begin
    clk_i = 1'b0;
    forever begin
      #10 clk_i = ~clk_i;
    end
  end

  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  task automatic accept;
    wr(`AORT_ADR_ACCEPT, 32'h0000_0001);
  endtask

  // Covers a computation in flight plus at least one full update after it.
  task automatic settle;
    repeat (3 * UPD) @(posedge clk_i);
  endtask

  task automatic chk_code(input logic [31:0] exp);
    rd(`AORT_ADR_CODE, exp);
    chk({16'h0000, dac_code_o}, exp);
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, fitted} = 4'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    mode = AORT_MODE_RATE;
    rate = 32'sh0000_01F4;
    total = 32'sh0000_00FA;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`AORT_ADR_LOW, 32'h0000_0005);
    rd(`AORT_ADR_LOW, 32'h0000_0000);
    rd(`AORT_ADR_STATUS, 32'h0000_0000);
    fitted <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({31'h0, param_visible_o}, 32'h0000_0001);
    rd(`AORT_ADR_LOW, 32'h0000_0000);
    rd(`AORT_ADR_HIGH, 32'h0000_03E8);
    rd(`AORT_ADR_SETPT, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    rd(`AORT_ADR_ACCEPT, 32'h0000_0000);
    // Retransmission across and beyond the programmed points.
    settle;
    chk_code(32'h0000_7FFF);
    rate <= -32'sh0000_0064;
    settle;
    chk_code(32'h0000_0000);
    rate <= 32'sh0000_07D0;
    settle;
    chk_code(32'h0000_FFFF);
    chk(level_uv, 32'h0098_9680);
    rate <= 32'sh0000_01F4;
    settle;
    chk_code(32'h0000_7FFF);
    // A staged high point must not move the output until accepted.
    chg_before = chg_cnt;
    wr(`AORT_ADR_HIGH, 32'h0000_07D0);
    settle;
    chk(chg_cnt, chg_before);
    chk_code(32'h0000_7FFF);
    accept;
    settle;
    chk_code(32'h0000_3FFF);
    // Source choice honoured only in the combined mode.
    wr(`AORT_ADR_CTRL, 32'h0000_0002);
    accept;
    settle;
    chk({31'h0, src_total_o}, 32'h0000_0000);
    chk_code(32'h0000_3FFF);
    mode <= AORT_MODE_BOTH;
    settle;
    chk({31'h0, src_total_o}, 32'h0000_0001);
    chk_code(32'h0000_1FFF);
    rd(`AORT_ADR_STATUS, 32'h0000_0005);
    mode <= AORT_MODE_TOTAL;
    wr(`AORT_ADR_CTRL, 32'h0000_0000);
    accept;
    settle;
    chk({31'h0, src_total_o}, 32'h0000_0001);
    // PI control with default tuning, then with edited tuning.
    mode <= AORT_MODE_RATE;
    wr(`AORT_ADR_CTRL, 32'h0000_0001);
    rd(`AORT_ADR_SPAN, 32'h0000_0000);
    accept;
    settle;
    chk({31'h0, pi_active_o}, 32'h0000_0001);
    // Poll status, bounded, until a control update is seen in flight.
    st = 32'h0000_0000;
    for (int i = 0; i < UPD && !st[`AORT_STAT_BUSY]; i++) begin
      bus(1'b0, `AORT_ADR_STATUS, 32'h0000_0000, st);
    end
    chk(st, 32'h0000_000B);
    rd(`AORT_ADR_SETPT, 32'h0000_0000);
    rd(`AORT_ADR_SPAN, 32'h0000_03E8);
    rd(`AORT_ADR_PGAIN, 32'h0000_03E8);
    rd(`AORT_ADR_IGAIN, 32'h0000_0000);
    rd(`AORT_ADR_IHI, 32'h0000_03E8);
    rd(`AORT_ADR_ILO, 32'h0000_0000);
    chk_code(32'h0000_0000);
    wr(`AORT_ADR_SETPT, 32'h0000_0320);
    accept;
    settle;
    chk_code(32'h0000_4CCC);
    wr(`AORT_ADR_IHI, 32'h0000_07D0);
    rd(`AORT_ADR_IHI, 32'h0000_03E8);
    wr(`AORT_ADR_IHI, 32'h0000_0064);
    wr(`AORT_ADR_IGAIN, 32'h0000_03E8);
    accept;
    settle;
    chk_code(32'h0000_6666);
    wr(`AORT_ADR_PGAIN, 32'hFFFF_FC18);
    rd(`AORT_ADR_PGAIN, 32'hFFFF_FC18);
    wr(`AORT_ADR_PGAIN, 32'h0000_0000);
    wr(`AORT_ADR_SETPT, 32'h0000_0000);
    wr(`AORT_ADR_ILO, 32'h0000_0032);
    wr(`AORT_ADR_ILO, 32'h0000_07D0);
    rd(`AORT_ADR_ILO, 32'h0000_0032);
    accept;
    settle;
    chk_code(32'h0000_0CCC);
    give_verdict();
  end
endmodule // aort_top_tb

`default_nettype wire
